// ==== verilog/bws_status_bank.sv ====
// Status register bank of bus, wake and switch flags behind an SPI slave.
// Assumes analog events arrive synchronous to clock; SPI pins are async.
`timescale 1ns/1ns
module bws_status_bank #(
	parameter int NUM_SW = 4,
	parameter int TX_EN_CNT = bws_pkg::TX_EN_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic spi_clk,
	input wire logic spi_csn,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oen,
	input wire bws_pkg::bws_can_evt_t can_evt,
	input wire bws_pkg::bws_can_mode_t can_mode,
	input wire logic can_txd,
	input wire logic can_bus_recessive,
	input wire logic selective_wake,
	input wire logic swk_config_error,
	input wire logic swk_counter_overflow,
	input wire logic can_silence_flag,
	input wire logic can_timeout_irq_mask,
	input wire logic irq_mode_active,
	input wire logic irq_pin_level,
	output logic irq_request,
	output logic can_tx_enable,
	output logic swk_enable_allowed,
	input wire bws_pkg::bws_wake_evt_t wake_evt,
	input wire bws_pkg::bws_wake_evt_t failsafe_exit_wake,
	input wire logic fail_output_test_pin,
	input wire logic int_pullup_present,
	input wire logic [2:0] wake_input_sample,
	input wire logic wake_sample_strobe,
	input wire logic [1:0] gp_pin_level_in,
	input wire logic [1:0] gp_pin_refresh,
	input wire logic [NUM_SW-1:0] sw_overload_evt,
	input wire logic [NUM_SW-1:0] sw_openload_evt
);
	////////////////////////////////////////////////////////////////////////
	// SPI pin synchronisers and edge detection
	logic [1:0] sclk_s_r, csn_s_r, sdi_s_r;
	logic sclk_d_r;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sclk_s_r <= 2'h0;
			csn_s_r <= 2'h3;
			sdi_s_r <= 2'h0;
			sclk_d_r <= 1'b0;
		end else begin
			sclk_s_r <= {sclk_s_r[0], spi_clk};
			csn_s_r <= {csn_s_r[0], spi_csn};
			sdi_s_r <= {sdi_s_r[0], spi_sdi};
			sclk_d_r <= sclk_s_r[1];
		end
	end
	wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
	wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
	wire cs_active = ~csn_s_r[1];

	////////////////////////////////////////////////////////////////////////
	// Frame shifter: bits 0..6 address, bit 7 mode, 8..15 data
	logic [4:0] bit_cnt_r;
	logic [6:0] addr_r;
	logic [7:0] shadow_r;
	logic mode_r;
	logic clear_pulse_r;
	logic [7:0] read_mux;
	wire addr_done = cs_active & sclk_rise
		& (bit_cnt_r == 5'(bws_pkg::ADDR_BITS - 1));
	wire mode_take = cs_active & sclk_rise
		& (bit_cnt_r == 5'(bws_pkg::MODE_BIT));
	wire frame_end = cs_active & sclk_rise
		& (bit_cnt_r == 5'(bws_pkg::FRAME_BITS - 1));
	wire [6:0] addr_full = {sdi_s_r[1], addr_r[6:1]};
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_r <= 5'h0;
			addr_r <= 7'h00;
			mode_r <= 1'b0;
		end else if (!cs_active) begin
			bit_cnt_r <= 5'h0;
		end else if (sclk_rise) begin
			bit_cnt_r <= bit_cnt_r + 5'h1;
			if (bit_cnt_r < 5'(bws_pkg::ADDR_BITS))
				addr_r <= addr_full;
			if (mode_take)
				mode_r <= sdi_s_r[1];
		end
	end
	// Shadow captured before any clear so the old value is sent
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			shadow_r <= 8'h00;
		else if (addr_done)
			shadow_r <= read_mux;
		else if (cs_active && sclk_fall && bit_cnt_r > 5'(bws_pkg::DATA_LSB))
			shadow_r <= {1'b0, shadow_r[7:1]};
	end
	// One clear pulse at end of a read/clear frame
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			clear_pulse_r <= 1'b0;
		else
			clear_pulse_r <= frame_end & mode_r;
	end
	// SDO: data byte LSB first in bits 8..15, zero before
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			spi_sdo <= 1'b0;
		else
			spi_sdo <= (bit_cnt_r >= 5'(bws_pkg::DATA_LSB)) & shadow_r[0];
	end
	assign spi_sdo_oen = ~cs_active;

	wire clr_bus = clear_pulse_r & (addr_r == bws_pkg::ADDR_BUS_COMM);
	wire clr_wka = clear_pulse_r & (addr_r == bws_pkg::ADDR_WAKE_A);
	wire clr_wkb = clear_pulse_r & (addr_r == bws_pkg::ADDR_WAKE_B);
	wire clr_ovl = clear_pulse_r & (addr_r == bws_pkg::ADDR_SW_OVL);
	wire clr_opn = clear_pulse_r & (addr_r == bws_pkg::ADDR_SW_OPEN);

	////////////////////////////////////////////////////////////////////////
	// CAN fault status
	logic [1:0] fail_code_r;
	logic can_supply_undervoltage_bit_r;
	logic swk_system_error_bit_r;
	logic can_timeout_flag_r;
	logic txd_fault_r, bus_fault_r;
	logic tx_block_r;
	logic [$clog2(TX_EN_CNT+1)-1:0] txd_high_cnt_r;
	wire can_active = (can_mode == bws_pkg::BWS_CAN_NORMAL)
		| (can_mode == bws_pkg::BWS_CAN_RXONLY);
	wire can_idle = (can_mode == bws_pkg::BWS_CAN_WAKE)
		| (can_mode == bws_pkg::BWS_CAN_OFF);
	wire uv_evt = can_evt.supply_undervoltage & can_active;
	wire any_fault = can_evt.thermal_shutdown | can_evt.txd_dominant_timeout
		| can_evt.bus_dominant_timeout | uv_evt;
	// Failure code, latest event by priority; set wins over clear
	wire [1:0] fail_nxt = can_evt.bus_dominant_timeout ? bws_pkg::FAIL_BUS_DOM
		: can_evt.txd_dominant_timeout ? bws_pkg::FAIL_TXD_DOM
		: can_evt.thermal_shutdown ? bws_pkg::FAIL_TSD
		: clr_bus ? bws_pkg::FAIL_NONE : fail_code_r;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fail_code_r <= bws_pkg::FAIL_NONE;
			can_supply_undervoltage_bit_r <= 1'b0;
			swk_system_error_bit_r <= 1'b0;
		end else begin
			fail_code_r <= fail_nxt;
			can_supply_undervoltage_bit_r <= uv_evt
				| (can_supply_undervoltage_bit_r & ~clr_bus);
			swk_system_error_bit_r <= (selective_wake
				& (swk_config_error | swk_counter_overflow))
				| (swk_system_error_bit_r & ~clr_bus);
		end
	end
	assign swk_enable_allowed = ~swk_system_error_bit_r;

	// Fault recovery and transmitter enable timing
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txd_fault_r <= 1'b0;
			bus_fault_r <= 1'b0;
			tx_block_r <= 1'b0;
			txd_high_cnt_r <= '0;
		end else begin
			if (can_evt.txd_dominant_timeout)
				txd_fault_r <= 1'b1;
			else if (can_txd || can_idle)
				txd_fault_r <= 1'b0;
			if (can_evt.bus_dominant_timeout)
				bus_fault_r <= 1'b1;
			else if (can_bus_recessive || can_idle)
				bus_fault_r <= 1'b0;
			if (any_fault || !can_txd)
				txd_high_cnt_r <= '0;
			else if (txd_high_cnt_r != TX_EN_CNT[$bits(txd_high_cnt_r)-1:0])
				txd_high_cnt_r <= txd_high_cnt_r + 1'b1;
			if (any_fault)
				tx_block_r <= 1'b1;
			else if (txd_high_cnt_r == TX_EN_CNT[$bits(txd_high_cnt_r)-1:0]
				&& !txd_fault_r && !bus_fault_r
				&& !(can_evt.supply_undervoltage && can_active))
				tx_block_r <= 1'b0;
		end
	end
	assign can_tx_enable = ~tx_block_r & can_active
		& ~(can_evt.supply_undervoltage & can_active);

	// Timeout flag with clear held off until interrupt falling edge
	logic irq_s0_r, irq_s1_r, irq_d_r;
	logic to_clear_ok_r;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_s0_r <= 1'b1;
			irq_s1_r <= 1'b1;
			irq_d_r <= 1'b1;
		end else begin
			irq_s0_r <= irq_pin_level;
			irq_s1_r <= irq_s0_r;
			irq_d_r <= irq_s1_r;
		end
	end
	wire irq_fall = ~irq_s1_r & irq_d_r;
	wire to_set = selective_wake & can_silence_flag;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			can_timeout_flag_r <= 1'b0;
			to_clear_ok_r <= 1'b0;
		end else begin
			if (to_set)
				can_timeout_flag_r <= 1'b1;
			else if (clr_bus && to_clear_ok_r)
				can_timeout_flag_r <= 1'b0;
			if (to_set && !can_timeout_flag_r)
				to_clear_ok_r <= 1'b0;
			else if (irq_fall)
				to_clear_ok_r <= 1'b1;
		end
	end
	assign irq_request = can_timeout_flag_r & can_timeout_irq_mask
		& irq_mode_active;

	////////////////////////////////////////////////////////////////////////
	// Wake latches
	bws_pkg::bws_wake_evt_t wake_r;
	wire bws_pkg::bws_wake_evt_t wake_set = wake_evt | failsafe_exit_wake;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			wake_r <= '0;
		else begin
			wake_r.bus <= wake_set.bus | (wake_r.bus & ~clr_wka);
			wake_r.timer <= wake_set.timer | (wake_r.timer & ~clr_wka);
			wake_r.wake_in <= wake_set.wake_in
				| (wake_r.wake_in & {3{~clr_wka}});
			wake_r.gp_pin <= wake_set.gp_pin
				| (wake_r.gp_pin & {2{~clr_wkb}});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Level register
	logic [2:0] wake_level_r;
	logic [1:0] gp_level_r;
	logic dev_s0_r, dev_s1_r, pu_s0_r, pu_s1_r;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wake_level_r <= 3'h0;
			dev_s0_r <= 1'b0;
			dev_s1_r <= 1'b0;
			pu_s0_r <= 1'b0;
			pu_s1_r <= 1'b0;
		end else begin
			if (wake_sample_strobe)
				wake_level_r <= wake_input_sample;
			dev_s0_r <= fail_output_test_pin;
			dev_s1_r <= dev_s0_r;
			pu_s0_r <= int_pullup_present;
			pu_s1_r <= pu_s0_r;
		end
	end
	// Per-pin GPIO level refresh
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_gp
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn)
					gp_level_r[g] <= 1'b0;
				else if (gp_pin_refresh[g])
					gp_level_r[g] <= gp_pin_level_in[g];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// High-side switch flags
	logic [NUM_SW-1:0] ovl_r, opn_r;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ovl_r <= '0;
			opn_r <= '0;
		end else begin
			ovl_r <= sw_overload_evt | (ovl_r & {NUM_SW{~clr_ovl}});
			opn_r <= sw_openload_evt | (opn_r & {NUM_SW{~clr_opn}});
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, reserved bits zero
	wire [7:0] rd_bus = {3'h0, can_timeout_flag_r, swk_system_error_bit_r,
		fail_code_r, can_supply_undervoltage_bit_r};
	wire [7:0] rd_wka = {2'h0, wake_r.bus, wake_r.timer, 1'b0,
		wake_r.wake_in};
	wire [7:0] rd_wkb = {2'h0, wake_r.gp_pin, 4'h0};
	wire [7:0] rd_lvl = {dev_s1_r, pu_s1_r, gp_level_r, 1'b0,
		wake_level_r};
	wire [7:0] rd_ovl = 8'(ovl_r);
	wire [7:0] rd_opn = 8'(opn_r);
	always_comb begin
		case (addr_full)
			bws_pkg::ADDR_BUS_COMM: read_mux = rd_bus;
			bws_pkg::ADDR_WAKE_A: read_mux = rd_wka;
			bws_pkg::ADDR_WAKE_B: read_mux = rd_wkb;
			bws_pkg::ADDR_LEVELS: read_mux = rd_lvl;
			bws_pkg::ADDR_SW_OVL: read_mux = rd_ovl;
			bws_pkg::ADDR_SW_OPEN: read_mux = rd_opn;
			default: read_mux = bws_pkg::RESET_VALUE;
		endcase
	end
endmodule

// ==== shared/bws_pkg.sv ====
// Package for the bus, wake and switch status bank.
// Assumes an SPI slave frame of 16 bits, LSB first, addressed by 7 bits.
package bws_pkg;
	// Register addresses (7-bit)
	localparam logic [6:0] ADDR_BUS_COMM = 7'h44;
	localparam logic [6:0] ADDR_WAKE_A = 7'h46;
	localparam logic [6:0] ADDR_WAKE_B = 7'h47;
	localparam logic [6:0] ADDR_LEVELS = 7'h48;
	localparam logic [6:0] ADDR_SW_OVL = 7'h54;
	localparam logic [6:0] ADDR_SW_OPEN = 7'h55;
	// Frame layout
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 7;
	localparam int MODE_BIT = 7;
	localparam int DATA_LSB = 8;
	// Field positions, bus status
	localparam int BUS_UV_POS = 0;
	localparam int BUS_FAIL_LSB = 1;
	localparam int BUS_SWK_SYSTEM_ERROR_BIT_POS = 3;
	localparam int BUS_TO_POS = 4;
	// Field positions, wake status and level register
	localparam int WKA_BUS_POS = 5;
	localparam int WKA_TIMER_POS = 4;
	localparam int WKB_GP_LSB = 4;
	localparam int LVL_GP_LSB = 4;
	localparam int LVL_PULLUP_POS = 6;
	localparam int LVL_DEV_POS = 7;
	// Failure codes
	localparam logic [1:0] FAIL_NONE = 2'h0;
	localparam logic [1:0] FAIL_TSD = 2'h1;
	localparam logic [1:0] FAIL_TXD_DOM = 2'h2;
	localparam logic [1:0] FAIL_BUS_DOM = 2'h3;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// Transmitter enable time
	localparam int TX_EN_TIME_NS = 4000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int TX_EN_CYCLES = (TX_EN_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// CAN transceiver mode
	typedef enum logic [1:0] {
		BWS_CAN_OFF,
		BWS_CAN_WAKE,
		BWS_CAN_RXONLY,
		BWS_CAN_NORMAL
	} bws_can_mode_t;
	// CAN fault events from the analog front end
	typedef struct packed {
		logic thermal_shutdown;
		logic txd_dominant_timeout;
		logic bus_dominant_timeout;
		logic supply_undervoltage;
	} bws_can_evt_t;
	// Wake events
	typedef struct packed {
		logic bus;
		logic timer;
		logic [2:0] wake_in;
		logic [1:0] gp_pin;
	} bws_wake_evt_t;
endpackage

// ==== tb/bws_status_bank_asserts.sv ====
// Checker on the port relations of the status bank.
// Assumes it is bound to every bws_status_bank instance.
`timescale 1ns/1ns
module bws_status_bank_asserts (
	input wire logic clock,
	input wire logic resetn,
	input wire logic spi_csn,
	input wire logic spi_sdo_oen,
	input wire bws_pkg::bws_can_evt_t can_evt,
	input wire bws_pkg::bws_can_mode_t can_mode,
	input wire logic selective_wake,
	input wire logic swk_config_error,
	input wire logic swk_counter_overflow,
	input wire logic can_silence_flag,
	input wire logic can_timeout_irq_mask,
	input wire logic irq_mode_active,
	input wire logic irq_request,
	input wire logic can_tx_enable,
	input wire logic swk_enable_allowed
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////
	// Steps of a fault, a system error, the timeout interrupt and the SDO release
	sequence s_fault;
		can_evt.thermal_shutdown || can_evt.txd_dominant_timeout
			|| can_evt.bus_dominant_timeout;
	endsequence
	sequence s_tx_off;
		!can_tx_enable [*3];
	endsequence
	sequence s_sys_err;
		selective_wake && (swk_config_error || swk_counter_overflow);
	endsequence
	property p_fault_block;
		s_fault |=> s_tx_off;
	endproperty
	property p_uv_block;
		can_evt.supply_undervoltage && can_mode[1] |=> !can_tx_enable;
	endproperty
	property p_swk_system_error_bit_set;
		s_sys_err |=> !swk_enable_allowed;
	endproperty
	property p_swk_system_error_bit_fall;
		$fell(swk_enable_allowed) |-> $past(selective_wake
			&& (swk_config_error || swk_counter_overflow));
	endproperty
	property p_irq_gate;
		irq_request |-> can_timeout_irq_mask && irq_mode_active;
	endproperty
	property p_irq_rise;
		$rose(irq_request) && $stable(can_timeout_irq_mask)
			&& $stable(irq_mode_active)
			|-> $past(selective_wake && can_silence_flag);
	endproperty
	property p_oen_release;
		$rose(spi_csn) |-> ##[2:5] spi_sdo_oen;
	endproperty
	property p_err_hold;
		spi_csn && !swk_enable_allowed |=> !swk_enable_allowed;
	endproperty
	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_fault_block: assert property (p_fault_block)
		else $error("transmitter on after fault");
	a_uv_block: assert property (p_uv_block)
		else $error("transmitter on after undervoltage");
	a_swk_system_error_bit_set: assert property (p_swk_system_error_bit_set)
		else $error("system error not set");
	a_swk_system_error_bit_fall: assert property (p_swk_system_error_bit_fall)
		else $error("enable withdrawn without cause");
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt while masked");
	a_irq_rise: assert property (p_irq_rise)
		else $error("timeout flag without silence");
	a_oen_release: assert property (p_oen_release)
		else $error("output not released");
	a_err_hold: assert property (p_err_hold)
		else $error("system error cleared without command");
endmodule
bind bws_status_bank bws_status_bank_asserts u_chk (.clock, .resetn,
	.spi_csn, .spi_sdo_oen, .can_evt, .can_mode, .selective_wake,
	.swk_config_error, .swk_counter_overflow, .can_silence_flag,
	.can_timeout_irq_mask, .irq_mode_active, .irq_request, .can_tx_enable,
	.swk_enable_allowed);

// ==== tb/bws_spi_master.sv ====
// Model of the controller that reads and clears the status bank.
// Assumes a 48 ns link clock that idles low and stands still between frames.
`timescale 1ns/1ns
module bws_spi_master (
	output logic spi_clk,
	output logic spi_csn,
	output logic spi_sdi,
	input wire logic sdo_line
);
	initial begin
		spi_clk = 1'b0;
		spi_csn = 1'b1;
		spi_sdi = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// One frame, LSB first; returns the byte shifted back
	task automatic frame(input logic [6:0] a, input logic m,
		output logic [7:0] d);
		logic [15:0] f;
		f = {8'h00, m, a};
		d = 8'h00;
		spi_csn = 1'b0;
		#48;
		for (int i = 0; i < 16; i++) begin
			spi_sdi = f[i];
			#24;
			if (i >= 8) d[i-8] = sdo_line;
			spi_clk = 1'b1;
			#24;
			spi_clk = 1'b0;
		end
		#48;
		spi_csn = 1'b1;
		spi_sdi = 1'b0; // Pulled down once released
		#200;
	endtask
endmodule

// ==== tb/test_bws_status_bank.sv ====
// Self-checking bench for the status bank.
// Assumes bws_spi_master as link partner and a short enable count.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
$display("[ERR] %0t got=%h exp=%h", $time, g, e); end end
module test_bws_status_bank;
	localparam int TXN = 4;
	logic clock, resetn, spi_clk, spi_csn, spi_sdi, spi_sdo, spi_sdo_oen;
	logic can_txd, can_bus_recessive, selective_wake, swk_config_error;
	logic swk_counter_overflow, can_silence_flag, can_timeout_irq_mask;
	logic irq_mode_active, irq_pin_level, irq_request, can_tx_enable;
	logic swk_enable_allowed, fail_output_test_pin, int_pullup_present;
	logic wake_sample_strobe;
	logic [2:0] wake_input_sample;
	logic [1:0] gp_pin_level_in, gp_pin_refresh;
	logic [3:0] sw_overload_evt, sw_openload_evt;
	logic [6:0] regs [6] = '{7'h44, 7'h46, 7'h47, 7'h54, 7'h55, 7'h45};
	bws_pkg::bws_can_evt_t can_evt;
	bws_pkg::bws_can_mode_t can_mode;
	bws_pkg::bws_wake_evt_t wake_evt, failsafe_exit_wake;
	int err_count = 0;
	int n_tests = 0;
	wire sdo_line = spi_sdo_oen ? 1'bz : spi_sdo;
	bws_status_bank #(.TX_EN_CNT(TXN)) DUT (.clock, .resetn, .spi_clk,
		.spi_csn, .spi_sdi, .spi_sdo, .spi_sdo_oen, .can_evt, .can_mode,
		.can_txd, .can_bus_recessive, .selective_wake, .swk_config_error,
		.swk_counter_overflow, .can_silence_flag, .can_timeout_irq_mask,
		.irq_mode_active, .irq_pin_level, .irq_request, .can_tx_enable,
		.swk_enable_allowed, .wake_evt, .failsafe_exit_wake,
		.fail_output_test_pin, .int_pullup_present, .wake_input_sample,
		.wake_sample_strobe, .gp_pin_level_in, .gp_pin_refresh,
		.sw_overload_evt, .sw_openload_evt);
	bws_spi_master master (.spi_clk, .spi_csn, .spi_sdi, .sdo_line);
	////////////////////////////////////////////////////////////////////////////
	// Clock and helpers
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [6:0] a, input logic m, input logic [7:0] e);
		logic [7:0] d;
		master.frame(a, m, d);
		`CHK(d, e)
	endtask
	task automatic conclude;
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog, about four times the expected run
	initial begin
		#120000;
		err_count++;
		conclude();
	end
	////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		resetn = 1'b0;
		{can_txd, can_bus_recessive, irq_mode_active, irq_pin_level} = 4'hf;
		{selective_wake, swk_config_error, swk_counter_overflow} = 3'h0;
		{can_silence_flag, can_timeout_irq_mask, wake_sample_strobe} = 3'h0;
		{fail_output_test_pin, int_pullup_present} = 2'h0;
		{wake_input_sample, gp_pin_level_in, gp_pin_refresh} = 7'h00;
		{sw_overload_evt, sw_openload_evt} = 8'h00;
		can_evt = '0;
		wake_evt = '0;
		failsafe_exit_wake = '0;
		can_mode = bws_pkg::BWS_CAN_NORMAL;
		tick(4);
		resetn = 1'b1;
		tick(4);
		foreach (regs[i]) rd(regs[i], 1'b1, 8'h00);
		// Each failure code, then transmitter recovery
		for (int k = 1; k < 4; k++) begin
			can_txd = 1'b0;
			can_evt = bws_pkg::bws_can_evt_t'(4'h8 >> (k - 1));
			tick(1);
			can_evt = '0;
			tick(2);
			`CHK(can_tx_enable, 1'b0)
			can_txd = 1'b1;
			tick(TXN + 4);
			`CHK(can_tx_enable, 1'b1)
			rd(7'h44, 1'b1, 8'(k << 1));
			rd(7'h44, 1'b0, 8'h00);
		end
		// Undervoltage only in active modes
		for (int k = 0; k < 2; k++) begin
			can_mode = k ? bws_pkg::BWS_CAN_RXONLY : bws_pkg::BWS_CAN_WAKE;
			can_evt = bws_pkg::bws_can_evt_t'(4'h1);
			tick(1);
			can_evt = '0;
			rd(7'h44, 1'b1, 8'(k));
		end
		can_mode = bws_pkg::BWS_CAN_NORMAL;
		// System error, gated by selective wake
		swk_config_error = 1'b1;
		tick(1);
		swk_config_error = 1'b0;
		rd(7'h44, 1'b0, 8'h00);
		selective_wake = 1'b1;
		for (int j = 1; j < 3; j++) begin
			{swk_config_error, swk_counter_overflow} = 2'(j);
			tick(1);
			{swk_config_error, swk_counter_overflow} = 2'h0;
			tick(1);
			`CHK(swk_enable_allowed, 1'b0)
			rd(7'h44, 1'b1, 8'h08);
			`CHK(swk_enable_allowed, 1'b1)
		end
		// Timeout flag, its interrupt and the blocked clear
		can_silence_flag = 1'b1;
		tick(1);
		can_silence_flag = 1'b0;
		tick(1);
		`CHK(irq_request, 1'b0)
		can_timeout_irq_mask = 1'b1;
		tick(1);
		`CHK(irq_request, 1'b1)
		rd(7'h44, 1'b1, 8'h10);
		rd(7'h44, 1'b0, 8'h10);
		irq_pin_level = 1'b0;
		tick(8);
		irq_pin_level = 1'b1;
		tick(8);
		rd(7'h44, 1'b1, 8'h10);
		rd(7'h44, 1'b0, 8'h00);
		`CHK(irq_request, 1'b0)
		selective_wake = 1'b0;
		can_silence_flag = 1'b1;
		tick(1);
		can_silence_flag = 1'b0;
		rd(7'h44, 1'b0, 8'h00);
		// Flag set while unmasked, then gated by operating mode
		selective_wake = 1'b1;
		can_silence_flag = 1'b1;
		tick(1);
		can_silence_flag = 1'b0;
		tick(1);
		`CHK(irq_request, 1'b1)
		irq_mode_active = 1'b0;
		tick(1);
		`CHK(irq_request, 1'b0)
		irq_mode_active = 1'b1;
		selective_wake = 1'b0;
		// Wake latches, direct and on fail-safe exit
		wake_evt = '1;
		tick(1);
		wake_evt = '0;
		rd(7'h46, 1'b1, 8'h37);
		rd(7'h47, 1'b1, 8'h30);
		failsafe_exit_wake = bws_pkg::bws_wake_evt_t'(7'h41);
		tick(1);
		failsafe_exit_wake = '0;
		rd(7'h46, 1'b1, 8'h20);
		rd(7'h47, 1'b0, 8'h10);
		// Level register: loaded values, then inputs move without load
		{fail_output_test_pin, int_pullup_present} = 2'h3;
		{wake_input_sample, gp_pin_level_in} = 5'h16;
		{wake_sample_strobe, gp_pin_refresh} = 3'h7;
		tick(1);
		{wake_sample_strobe, gp_pin_refresh} = 3'h0;
		{wake_input_sample, gp_pin_level_in} = 5'h09;
		tick(4);
		rd(7'h48, 1'b1, 8'he5);
		// Switch flags
		{sw_overload_evt, sw_openload_evt} = 8'h96;
		tick(1);
		{sw_overload_evt, sw_openload_evt} = 8'h00;
		rd(7'h54, 1'b1, 8'h09);
		rd(7'h55, 1'b1, 8'h06);
		rd(7'h54, 1'b0, 8'h00);
		conclude();
	end
endmodule
